// >>> logic/dsd_pkg.sv
// Constants, register map and types shared by the diagnostic telegram framer.
package dsd_pkg;

  // ****************************************************************
  // Telegram layout
  // ****************************************************************
  localparam int DSD_MAX_LEN = 127;
  localparam int DSD_STD_LEN = 6;
  localparam int DSD_ID_LEN = 4;
  localparam int DSD_MS_LEN = 9;
  localparam int DSD_CH_BYTES = 3;
  localparam int DSD_CH_MAX = 40;
  localparam int DSD_IR_LEN = 12;
  localparam int DSD_SLOTS = 20;
  localparam int DSD_BYTE_BITS = 8;
  localparam int DSD_WORD_BITS = 32;
  localparam int DSD_MS_SLOT_OFS = 4;
  localparam int DSD_SYNC_W = 6 * DSD_SLOTS;
  // Byte positions inside the standard block.
  localparam int DSD_B_FLAGS0 = 0;
  localparam int DSD_B_FLAGS1 = 1;
  localparam int DSD_B_OVF = 2;
  localparam int DSD_B_MADDR = 3;
  localparam int DSD_B_IDHI = 4;
  localparam int DSD_B_IDLO = 5;
  // Fixed section bytes.
  localparam logic [7:0] DSD_ID_HDR = 8'h45;
  localparam logic [7:0] DSD_MS_HDR = 8'h0C;
  localparam logic [7:0] DSD_MS_TYPE = 8'h82;
  localparam logic [7:0] DSD_MS_ZERO = 8'h00;
  localparam logic [7:0] DSD_NO_MASTER = 8'hFF;
  localparam logic [7:0] DSD_STD0_MASK = 8'h5E;
  localparam logic [7:0] DSD_STD1_MASK = 8'h3B;
  localparam logic [7:0] DSD_STD1_ONE = 8'h04;
  localparam int DSD_STD2_OVF = 7;
  localparam logic [7:0] DSD_FLAGS0_RST = 8'h02;
  localparam logic [7:0] DSD_FLAGS1_RST = 8'h01;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam int DSD_ADR_W = 10;
  localparam logic [9:0] DSD_REG_CTRL = 10'h000;
  localparam logic [9:0] DSD_REG_FLAGS = 10'h004;
  localparam logic [9:0] DSD_REG_MADDR = 10'h008;
  localparam logic [9:0] DSD_REG_IDENT = 10'h00C;
  localparam logic [9:0] DSD_REG_CHCNT = 10'h010;
  localparam logic [9:0] DSD_REG_STATUS = 10'h014;
  localparam logic [9:0] DSD_REG_IDBITS = 10'h018;
  localparam logic [9:0] DSD_REG_IRQ = 10'h020;
  localparam logic [9:0] DSD_REG_CHAN = 10'h100;
  // Field positions.
  localparam int DSD_EN_ID = 0;
  localparam int DSD_EN_MS = 1;
  localparam int DSD_EN_CH = 2;
  localparam int DSD_EN_IR = 3;
  localparam int DSD_CTRL_PRM = 8;
  localparam int DSD_FLAGS_SWOVF = 16;
  localparam int DSD_STS_OVF = 8;
  localparam int DSD_STS_BUSY = 9;

  typedef enum logic {DSD_IDLE, DSD_SEND} dsd_state_e;

endpackage

// >>> logic/dsd_len_if.sv
// Interface carrying section enables and the computed telegram layout.
interface dsd_len_if;
  logic [3:0] en;
  logic [5:0] chan_req;
  logic [6:0] ms_base;
  logic [6:0] ch_base;
  logic [6:0] ir_base;
  logic [6:0] total;
  logic [5:0] chan_use;
  logic ovf;
  modport calc (input en, chan_req, output ms_base, ch_base, ir_base, total, chan_use, ovf);
  modport user (output en, chan_req, input ms_base, ch_base, ir_base, total, chan_use, ovf);
endinterface

// >>> logic/dsd_sync.sv
// Two-flop synchroniser for the rack slot condition pins.
module dsd_sync #(
  parameter int W = 8  // Number of bits carried across.
) (
  input wire logic clk_i,  // System clock.
  input wire logic rst_i,  // Synchronous reset, active high.
  input wire logic ce_i,  // Clock enable; state holds while low.
  input wire logic [W-1:0] d_i,  // Asynchronous pin levels.
  output logic [W-1:0] q_o  // Levels safe to use on clk_i.
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } dsd_sync_s;
  dsd_sync_s st_r;
  dsd_sync_s st_nxt;

  // The first stage feeds only the second, so metastability cannot spread.
  always_comb begin
    st_nxt.meta = d_i;
    st_nxt.safe = st_r.meta;
  end

  // Register the whole state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.safe;
endmodule

// >>> logic/dsd_len.sv
// Section placement and length budget of the diagnostic telegram.
module dsd_len
  import dsd_pkg::*;
(
  dsd_len_if.calc lif  // Section enables in, layout out.
);
  logic [7:0] fixed_len;
  logic [7:0] ir_len;
  logic [7:0] room;
  logic [5:0] fit;
  logic [5:0] req;

  // Sections follow each other in fixed order; channels get what is left.
  always_comb begin
    fixed_len = 8'(DSD_STD_LEN);
    if (lif.en[DSD_EN_ID]) begin  // see RULE2
      fixed_len = fixed_len + 8'(DSD_ID_LEN);
    end
    lif.ms_base = 7'(fixed_len);
    if (lif.en[DSD_EN_MS]) begin
      fixed_len = fixed_len + 8'(DSD_MS_LEN);
    end
    lif.ch_base = 7'(fixed_len);
    ir_len = lif.en[DSD_EN_IR] ? 8'(DSD_IR_LEN) : 8'h00;
    // Budget left for channel entries under the overall cap.
    room = 8'(DSD_MAX_LEN) - fixed_len - ir_len;  // see RULE1
    fit = '0;
    for (int n = 1; n <= DSD_CH_MAX; n++) begin
      if (n * DSD_CH_BYTES <= int'(room)) begin  // see RULE15
        fit = 6'(n);
      end
    end
    req = (int'(lif.chan_req) > DSD_CH_MAX) ? 6'(DSD_CH_MAX) : lif.chan_req;
    lif.chan_use = '0;
    lif.ovf = 1'b0;
    if (lif.en[DSD_EN_CH]) begin
      lif.chan_use = (req > fit) ? fit : req;  // see RULE17
      lif.ovf = (lif.chan_req > fit);
    end
    // The interrupt section sits behind everything else.
    lif.ir_base = lif.ch_base + 7'(lif.chan_use) * 7'(DSD_CH_BYTES);  // see RULE16
    lif.total = lif.ir_base + 7'(ir_len);
  end
endmodule

// >>> logic/dsd_telegram.sv
// Slave diagnostic telegram framer with its Wishbone register slave.
// Behaviour
// RULE1: Whole telegram never exceeds 127 bytes.
// RULE2: Standard bytes first, then enabled sections in order.
// RULE3: Byte 0 station flags, bits 0,5,7 zero.
// RULE4: Byte 1 flags, bit 2 one, bit 7 zero.
// RULE5: Byte 2 bit 7 marks diagnostic overflow.
// RULE6: Byte 3 master address, FFh when unparameterized.
// RULE7: Bytes 4,5 ident number, high byte first.
// RULE8: Bitmap header holds length 000101, code 01.
// RULE9: Slot fault conditions set that slot's bitmap bit.
// RULE10: Slots 1..20 packed low bit first, three bytes.
// RULE11: Status header holds length 001100, code 00.
// RULE12: Status type 82h, then two 00h bytes.
// RULE13: Two-bit slot codes: ok, defective, wrong, absent.
// RULE14: Slot codes four per byte from fifth byte.
// RULE15: Every channel entry is exactly three bytes.
// RULE16: Interrupt section always placed last.
// RULE17: Excess channel entries dropped, overflow flag set.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
module dsd_telegram
  import dsd_pkg::*;
#(
  parameter logic [15:0] IDENT_RST = 16'h5A5A  // Ident number after reset; value is arbitrary.
) (
  input wire logic clk_i,  // System clock, 100 MHz.
  input wire logic rst_i,  // Synchronous reset, active high.
  input wire logic ce_i,  // Clock enable; all state holds while low.
  input wire logic wb_cyc_i,  // Wishbone cycle.
  input wire logic wb_stb_i,  // Wishbone strobe.
  input wire logic wb_we_i,  // Wishbone write enable.
  input wire logic [DSD_ADR_W-1:0] wb_adr_i,  // Wishbone byte address.
  input wire logic [3:0] wb_sel_i,  // Wishbone byte lanes.
  input wire logic [31:0] wb_dat_i,  // Wishbone write data.
  output logic [31:0] wb_dat_o,  // Wishbone read data.
  output logic wb_ack_o,  // Wishbone acknowledge.
  input wire logic [DSD_SLOTS-1:0] slot_removed_i,  // Module pulled from slot.
  input wire logic [DSD_SLOTS-1:0] slot_unconf_i,  // Unconfigured module fitted.
  input wire logic [DSD_SLOTS-1:0] slot_noacc_i,  // Module cannot be accessed.
  input wire logic [DSD_SLOTS-1:0] slot_diag_i,  // Module raises diagnostic interrupt.
  input wire logic [2*DSD_SLOTS-1:0] slot_stat_i,  // Two-bit status per slot.
  input wire logic tx_start_i,  // Request one telegram.
  input wire logic tx_ready_i,  // Reader accepts the byte.
  output logic [7:0] tx_byte_o,  // Telegram byte.
  output logic tx_valid_o,  // Byte valid.
  output logic tx_last_o  // Final byte of the telegram.
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [3:0] en;
    logic prm;
    logic [7:0] flags0;
    logic [7:0] flags1;
    logic sw_ovf;
    logic [7:0] maddr;
    logic [15:0] ident;
    logic [5:0] chan_cnt;
    logic [DSD_IR_LEN*DSD_BYTE_BITS-1:0] irq;
    logic [DSD_CH_MAX-1:0][DSD_CH_BYTES*DSD_BYTE_BITS-1:0] chan;
    logic [DSD_SLOTS-1:0] id_bits;
    logic [DSD_SLOTS-1:0] snap_id;
    dsd_state_e state;
    logic [3:0] snap_en;
    logic [5:0] snap_cnt;
    logic [6:0] idx;
    logic [5:0] ch_k;
    logic [1:0] ch_j;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_last;
  } dsd_top_s;
  dsd_top_s st_r;
  dsd_top_s st_nxt;

  logic [DSD_SYNC_W-1:0] slot_raw;
  logic [DSD_SYNC_W-1:0] slot_sync;
  logic [DSD_SLOTS-1:0] id_set;
  logic [2*DSD_SLOTS-1:0] ms_pack;
  logic ovf_all;
  logic bus_req;
  logic [7:0] wa;
  logic ch_hit;
  logic ir_hit;
  logic [5:0] ch_sel;
  logic [1:0] ir_sel;
  logic [31:0] rd_word;
  logic [31:0] ch_word;
  logic [6:0] nidx;
  logic [5:0] nk;
  logic [1:0] nj;

  // ****************************************************************
  // Rack inputs and layout
  // ****************************************************************
  assign slot_raw = {slot_stat_i, slot_diag_i, slot_noacc_i, slot_unconf_i, slot_removed_i};

  dsd_sync #(
    .W(DSD_SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(slot_raw),
    .q_o(slot_sync)
  );

  // Any of the four slot faults marks the slot in the bitmap.
  assign id_set = slot_sync[0 +: DSD_SLOTS] | slot_sync[DSD_SLOTS +: DSD_SLOTS]
    | slot_sync[2*DSD_SLOTS +: DSD_SLOTS] | slot_sync[3*DSD_SLOTS +: DSD_SLOTS];  // see RULE9
  // Status codes pass through unchanged, slot 1 in the lowest pair.
  assign ms_pack = slot_sync[4*DSD_SLOTS +: 2*DSD_SLOTS];  // see RULE13

  dsd_len_if lif();

  dsd_len u_len (
    .lif(lif)
  );

  // The layout is frozen while a telegram is on its way out.
  assign lif.en = (st_r.state == DSD_SEND) ? st_r.snap_en : st_r.en;
  assign lif.chan_req = (st_r.state == DSD_SEND) ? st_r.snap_cnt : st_r.chan_cnt;
  assign ovf_all = st_r.sw_ovf | lif.ovf;  // see RULE17

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Merge write data into a word under the byte lanes.
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] w;
    w = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        w[b*DSD_BYTE_BITS +: DSD_BYTE_BITS] = dat[b*DSD_BYTE_BITS +: DSD_BYTE_BITS];
      end
    end
    return w;
  endfunction

  // Word address match against a register byte offset.
  function automatic logic hit(input logic [9:0] off);
    return wa == off[DSD_ADR_W-1:2];
  endfunction

  // Telegram byte at position i; k and j walk the channel entries.
  function automatic logic [7:0] byte_at(input logic [6:0] i, input logic [5:0] k,
                                         input logic [1:0] j);
    logic [7:0] b;
    logic [6:0] r;
    logic [2:0] rr;
    b = 8'h00;
    r = '0;
    rr = '0;
    if (i < 7'(DSD_STD_LEN)) begin
      case (int'(i))
        DSD_B_FLAGS0: b = st_r.flags0 & DSD_STD0_MASK;  // see RULE3
        DSD_B_FLAGS1: b = (st_r.flags1 & DSD_STD1_MASK) | DSD_STD1_ONE;  // see RULE4
        DSD_B_OVF: b[DSD_STD2_OVF] = ovf_all;  // see RULE5
        DSD_B_MADDR: b = st_r.prm ? st_r.maddr : DSD_NO_MASTER;  // see RULE6
        DSD_B_IDHI: b = st_r.ident[15:8];  // see RULE7
        DSD_B_IDLO: b = st_r.ident[7:0];
        default: b = 8'h00;
      endcase
    end else if (i < lif.ms_base) begin
      r = i - 7'(DSD_STD_LEN);
      unique case (r[1:0])
        2'h0: b = DSD_ID_HDR;  // see RULE8
        2'h1: b = st_r.snap_id[7:0];  // see RULE10
        2'h2: b = st_r.snap_id[15:8];
        2'h3: b = {4'h0, st_r.snap_id[DSD_SLOTS-1:16]};
      endcase
    end else if (i < lif.ch_base) begin
      r = i - lif.ms_base;
      rr = 3'(r - 7'(DSD_MS_SLOT_OFS));
      if (r == 7'h00) begin
        b = DSD_MS_HDR;  // see RULE11
      end else if (r == 7'h01) begin
        b = DSD_MS_TYPE;  // see RULE12
      end else if (r < 7'(DSD_MS_SLOT_OFS)) begin
        b = DSD_MS_ZERO;
      end else begin
        b = ms_pack[int'(rr)*DSD_BYTE_BITS +: DSD_BYTE_BITS];  // see RULE14
      end
    end else if (i < lif.ir_base) begin
      b = st_r.chan[k][int'(j)*DSD_BYTE_BITS +: DSD_BYTE_BITS];  // see RULE15
    end else begin
      r = i - lif.ir_base;
      b = st_r.irq[int'(r[3:0])*DSD_BYTE_BITS +: DSD_BYTE_BITS];  // see RULE16
    end
    return b;
  endfunction

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Answer one cycle after the request; unmapped words read zero.
  assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wa = wb_adr_i[DSD_ADR_W-1:2];
  assign ch_hit = (wa >= DSD_REG_CHAN[DSD_ADR_W-1:2])
    && (int'(wa) < int'(DSD_REG_CHAN[DSD_ADR_W-1:2]) + DSD_CH_MAX);
  assign ir_hit = (wa >= DSD_REG_IRQ[DSD_ADR_W-1:2])
    && (int'(wa) < int'(DSD_REG_IRQ[DSD_ADR_W-1:2]) + DSD_IR_LEN / 4);
  assign ch_sel = 6'(wa - DSD_REG_CHAN[DSD_ADR_W-1:2]);
  assign ir_sel = 2'(wa - DSD_REG_IRQ[DSD_ADR_W-1:2]);
  assign ch_word = {8'h00, st_r.chan[ch_sel]};

  // Read multiplexer.
  always_comb begin
    rd_word = '0;
    if (hit(DSD_REG_CTRL)) begin
      rd_word[3:0] = st_r.en;
      rd_word[DSD_CTRL_PRM] = st_r.prm;
    end else if (hit(DSD_REG_FLAGS)) begin
      rd_word[15:0] = {st_r.flags1, st_r.flags0};
      rd_word[DSD_FLAGS_SWOVF] = st_r.sw_ovf;
    end else if (hit(DSD_REG_MADDR)) begin
      rd_word[7:0] = st_r.maddr;
    end else if (hit(DSD_REG_IDENT)) begin
      rd_word[15:0] = st_r.ident;
    end else if (hit(DSD_REG_CHCNT)) begin
      rd_word[5:0] = st_r.chan_cnt;
    end else if (hit(DSD_REG_STATUS)) begin
      rd_word[6:0] = lif.total;
      rd_word[DSD_STS_OVF] = ovf_all;
      rd_word[DSD_STS_BUSY] = (st_r.state == DSD_SEND);
    end else if (hit(DSD_REG_IDBITS)) begin
      rd_word[DSD_SLOTS-1:0] = st_r.id_bits;
    end else if (ir_hit) begin
      rd_word = st_r.irq[int'(ir_sel)*DSD_WORD_BITS +: DSD_WORD_BITS];
    end else if (ch_hit) begin
      rd_word = ch_word;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    nidx = st_r.idx + 7'h01;
    nk = st_r.ch_k;
    nj = st_r.ch_j;
    // Bus slave: each request is answered by a single ack pulse.
    st_nxt.ack = bus_req;
    if (bus_req) begin
      st_nxt.rdat = rd_word;
      if (wb_we_i) begin
        if (hit(DSD_REG_CTRL)) begin
          st_nxt.en = 4'(wmerge(32'(st_r.en), wb_dat_i, wb_sel_i));
          st_nxt.prm = wb_sel_i[1] ? wb_dat_i[DSD_CTRL_PRM] : st_r.prm;
        end else if (hit(DSD_REG_FLAGS)) begin
          // Fixed bits are never stored, so they read back as zero.
          st_nxt.flags0 = wb_sel_i[0] ? (wb_dat_i[7:0] & DSD_STD0_MASK) : st_r.flags0;
          st_nxt.flags1 = wb_sel_i[1] ? (wb_dat_i[15:8] & DSD_STD1_MASK) : st_r.flags1;
          st_nxt.sw_ovf = wb_sel_i[2] ? wb_dat_i[DSD_FLAGS_SWOVF] : st_r.sw_ovf;
        end else if (hit(DSD_REG_MADDR)) begin
          st_nxt.maddr = wb_sel_i[0] ? wb_dat_i[7:0] : st_r.maddr;
        end else if (hit(DSD_REG_IDENT)) begin
          st_nxt.ident = 16'(wmerge(32'(st_r.ident), wb_dat_i, wb_sel_i));
        end else if (hit(DSD_REG_CHCNT)) begin
          st_nxt.chan_cnt = wb_sel_i[0] ? wb_dat_i[5:0] : st_r.chan_cnt;
        end else if (ir_hit) begin
          st_nxt.irq[int'(ir_sel)*DSD_WORD_BITS +: DSD_WORD_BITS] =
            wmerge(st_r.irq[int'(ir_sel)*DSD_WORD_BITS +: DSD_WORD_BITS], wb_dat_i, wb_sel_i);
        end else if (ch_hit) begin
          st_nxt.chan[ch_sel] = 24'(wmerge(ch_word, wb_dat_i, wb_sel_i));
        end
      end
    end
    // Channel cursor for the next byte position.
    if (nidx == lif.ch_base) begin
      nk = '0;
      nj = '0;
    end else if (nidx > lif.ch_base && nidx < lif.ir_base) begin
      if (int'(st_r.ch_j) == DSD_CH_BYTES - 1) begin  // see RULE15
        nk = st_r.ch_k + 6'h01;
        nj = '0;
      end else begin
        nj = st_r.ch_j + 2'h1;
      end
    end
    // Framer: one byte per accepted handshake, layout frozen at start.
    unique case (st_r.state)
      DSD_IDLE: begin
        if (tx_start_i) begin
          st_nxt.state = DSD_SEND;
          st_nxt.snap_en = st_r.en;
          st_nxt.snap_cnt = st_r.chan_cnt;
          st_nxt.snap_id = st_r.id_bits;
          st_nxt.idx = '0;
          st_nxt.ch_k = '0;
          st_nxt.ch_j = '0;
          st_nxt.tx_byte = byte_at(7'h00, 6'h00, 2'h0);  // see RULE2
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_last = (lif.total == 7'h01);
        end
      end
      DSD_SEND: begin
        if (st_r.tx_valid && tx_ready_i) begin
          if (st_r.tx_last) begin
            st_nxt.state = DSD_IDLE;
            st_nxt.tx_valid = 1'b0;
            st_nxt.tx_last = 1'b0;
          end else begin
            st_nxt.idx = nidx;
            st_nxt.ch_k = nk;
            st_nxt.ch_j = nj;
            st_nxt.tx_byte = byte_at(nidx, nk, nj);
            st_nxt.tx_last = (nidx + 7'h01 == lif.total);  // see RULE1
          end
        end
      end
    endcase
    // Reported bits clear once the telegram is out; a new fault wins.
    st_nxt.id_bits = st_r.id_bits | id_set;  // see RULE9
    if (st_r.state == DSD_SEND && st_r.tx_valid && tx_ready_i && st_r.tx_last) begin
      st_nxt.id_bits = (st_r.id_bits & ~st_r.snap_id) | id_set;
    end
  end

  // Register the whole state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.maddr <= DSD_NO_MASTER;
      st_r.ident <= IDENT_RST;
      st_r.flags0 <= DSD_FLAGS0_RST;
      st_r.flags1 <= DSD_FLAGS1_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign tx_byte_o = st_r.tx_byte;
  assign tx_valid_o = st_r.tx_valid;
  assign tx_last_o = st_r.tx_last;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_len_cap;
    @(posedge clk_i) disable iff (rst_i)
      st_r.tx_valid |-> (lif.total <= 7'(DSD_MAX_LEN)) && (st_r.idx < lif.total);
  endproperty
  a_len_cap: assert property (p_len_cap) else $error("telegram length over limit"); // see RULE1

  property p_last_pos;
    @(posedge clk_i) disable iff (rst_i)
      st_r.tx_valid && st_r.tx_last |-> (st_r.idx + 7'h01) == lif.total;
  endproperty
  a_last_pos: assert property (p_last_pos) else $error("last byte misplaced"); // see RULE2

  property p_std0;
    @(posedge clk_i) disable iff (rst_i)
      st_r.tx_valid && st_r.idx == 7'(DSD_B_FLAGS0) |-> (st_r.tx_byte & ~DSD_STD0_MASK) == 8'h00;
  endproperty
  a_std0: assert property (p_std0) else $error("fixed zero bits set in byte 0"); // see RULE3

  property p_std1;
    @(posedge clk_i) disable iff (rst_i)
      st_r.tx_valid && st_r.idx == 7'(DSD_B_FLAGS1)
      |-> (st_r.tx_byte & ~(DSD_STD1_MASK | DSD_STD1_ONE)) == 8'h00 && st_r.tx_byte[2];
  endproperty
  a_std1: assert property (p_std1) else $error("byte 1 fixed bits wrong"); // see RULE4

  property p_ovf;
    @(posedge clk_i) disable iff (rst_i)
      st_r.tx_valid && st_r.idx == 7'(DSD_B_OVF) && lif.ovf |-> st_r.tx_byte[DSD_STD2_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // see RULE17

  property p_maddr;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && st_r.tx_valid && tx_ready_i && st_r.idx == 7'(DSD_B_OVF) && !st_r.prm
      |=> st_r.tx_byte == DSD_NO_MASTER;
  endproperty
  a_maddr: assert property (p_maddr) else $error("unparameterized address not FFh"); // see RULE6

  property p_ident;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && st_r.tx_valid && tx_ready_i && st_r.idx == 7'(DSD_B_MADDR)
      |=> st_r.tx_byte == $past(st_r.ident[15:8]);
  endproperty
  a_ident: assert property (p_ident) else $error("ident high byte wrong"); // see RULE7

  property p_id_hdr;
    @(posedge clk_i) disable iff (rst_i)
      st_r.tx_valid && lif.en[DSD_EN_ID] && st_r.idx == 7'(DSD_STD_LEN)
      |-> st_r.tx_byte == DSD_ID_HDR;
  endproperty
  a_id_hdr: assert property (p_id_hdr) else $error("bitmap header wrong"); // see RULE8

  property p_id_set;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && (id_set != '0) |=> (st_r.id_bits & $past(id_set)) == $past(id_set);
  endproperty
  a_id_set: assert property (p_id_set) else $error("slot fault not recorded"); // see RULE9

  property p_ms_hdr;
    @(posedge clk_i) disable iff (rst_i)
      st_r.tx_valid && lif.en[DSD_EN_MS] && st_r.idx == lif.ms_base
      |-> st_r.tx_byte == DSD_MS_HDR;
  endproperty
  a_ms_hdr: assert property (p_ms_hdr) else $error("status header wrong"); // see RULE11

  property p_ms_type;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && st_r.tx_valid && tx_ready_i && lif.en[DSD_EN_MS] && st_r.idx == lif.ms_base
      |=> st_r.tx_byte == DSD_MS_TYPE;
  endproperty
  a_ms_type: assert property (p_ms_type) else $error("status type not 82h"); // see RULE12

  property p_ir_last;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && st_r.tx_valid && tx_ready_i && lif.en[DSD_EN_IR] && st_r.idx + 7'h02 == lif.total
      |=> st_r.tx_byte == $past(st_r.irq[DSD_IR_LEN*DSD_BYTE_BITS-1 -: DSD_BYTE_BITS]);
  endproperty
  a_ir_last: assert property (p_ir_last) else $error("interrupt section not last"); // see RULE16
endmodule

// >>> testbench/dsd_reader.sv
// Reader model of the master side that collects one diagnostic telegram.
module dsd_reader (
  input wire logic clk_i,  // System clock.
  input wire logic clr_i,  // Clears the byte store.
  input wire logic stall_i,  // Accept only every other cycle.
  input wire logic [7:0] byte_i,  // Telegram byte.
  input wire logic valid_i,  // Byte valid.
  input wire logic last_i,  // Final byte.
  output logic ready_o = 1'b0,  // Byte accepted.
  output logic done_o = 1'b0  // Final byte taken.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [128];
  int n = 0;
  // A slow master stalls every other cycle so held bytes are exercised.
  always @(posedge clk_i) begin
    ready_o <= stall_i ? ~ready_o : 1'b1;
    if (clr_i) begin
      n <= 0;
      done_o <= 1'b0;
    end else if (valid_i && ready_o) begin
      got[n[6:0]] <= byte_i;
      n <= n + 1;
      done_o <= last_i;
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the diagnostic telegram framer.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dsd_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, st = 0, clr = 1, stall = 0;
  logic [9:0] adr = '0;
  logic [31:0] wd = '0, rd, q;
  logic ack, vld, lst, rdy, dn;
  logic [7:0] tb;
  logic [19:0] rm = '0, uc = '0, na = '0, dg = '0;
  logic [39:0] ss = '0;
  int failures = 0, checks_done = 0;
  // Expected first telegram: standard, bitmap and status sections.
  logic [7:0] e1 [19] = '{8'h5E, 8'h3F, 8'h00, 8'hFF, 8'h5A, 8'h5A, 8'h45, 8'h01, 8'h09,
    8'h08, 8'h0C, 8'h82, 8'h00, 8'h00, 8'h39, 8'h00, 8'h00, 8'h00, 8'hC0};
  dsd_telegram DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .slot_removed_i(rm), .slot_unconf_i(uc), .slot_noacc_i(na),
    .slot_diag_i(dg), .slot_stat_i(ss), .tx_start_i(st), .tx_ready_i(rdy),
    .tx_byte_o(tb), .tx_valid_o(vld), .tx_last_o(lst));
  dsd_reader R (.clk_i(clk_i), .clr_i(clr), .stall_i(stall), .byte_i(tb), .valid_i(vld),
    .last_i(lst), .ready_o(rdy), .done_o(dn));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Classic single cycle; data taken at the edge that samples ack high.
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
    stb <= 0;
  endtask
  // One start pulse, then wait for the reader to take the final byte.
  task send();
    @(posedge clk_i);
    clr <= 0;
    st <= 1;
    @(posedge clk_i);
    st <= 0;
    do @(posedge clk_i); while (dn !== 1'b1);
    clr <= 1;
  endtask
  task wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 10'h3FC, 0);
    chk(q, 0);
    rm <= 20'h00001;
    uc <= 20'h00100;
    na <= 20'h80000;
    dg <= 20'h00800;
    ss <= 40'hC000000039;
    wb(1, DSD_REG_FLAGS, 32'hFFFF);
    wb(1, DSD_REG_CTRL, 32'h3);
    send();
    chk(R.n, 19);
    for (int i = 0; i < 19; i++) chk(R.got[i], e1[i]);
    wb(0, DSD_REG_IDBITS, 0);
    chk(q, 32'h80901);
    wb(1, DSD_REG_FLAGS, 0);
    wb(1, DSD_REG_MADDR, 32'h12);
    wb(1, DSD_REG_CHAN, 32'h332211);
    wb(1, DSD_REG_IRQ + 10'h8, 32'hAB000000);
    wb(1, DSD_REG_CHCNT, 40);
    wb(1, DSD_REG_CTRL, 32'h10F);
    stall <= 1;
    send();
    chk(R.n, 127);
    chk({R.got[2], R.got[3]}, 16'h8012);
    chk({R.got[19], R.got[20], R.got[21]}, 24'h112233);
    chk(R.got[126], 8'hAB);
    wb(0, DSD_REG_STATUS, 0);
    chk(q, 32'h17F);
    wrap_up();
  end
endmodule
